// >>> src/flow_gate_defs.svh
`ifndef FLOW_GATE_DEFS_SVH
`define FLOW_GATE_DEFS_SVH
// Notes on behaviour
// - no request leaves without a request credit in hand
// - writes and atomics also need one data credit, one line each
// - response buffering, with or without data, is reserved before issue
// - coherent read: request, completion with payload, then final ack
// - home returns coherent read data inside completion_with_payload
// - ack omit drops the coherent read final ack; home keeps snoops ordered
// - non-coherent and io reads finish on completion_with_payload, no ack
// - flush and discard dataless ops get exactly one done_resp, nothing more
// - permission gains get one done_resp, then requester sends final ack
// - ack omit drops the permission gain final ack as well
// - every write costs request and data credit, answered by done_resp
// - atomics cost both credits; no-return gets done_resp, others payload
// - no snoop leaves without a snoop credit
// - snoop response buffering is reserved before the snoop leaves
// - credited misc needs misc credits covering its whole length
// - one misc credit per eight byte unit of message
// - uncredited misc goes without credit and is always accepted
// - at most one snoop per line outstanding at any time
`define OPW 5
`define OP_COH_READ_FOR_OWNERSHIP 5'h00
`define OP_COH_READ_CLEAN_COPY 5'h01
`define OP_COH_READ_NO_DIRTY_SHARE 5'h02
`define OP_COH_READ_SHARABLE 5'h03
`define OP_NONSNOOPED_READ 5'h04
`define OP_IO_READ_SNAPSHOT 5'h05
`define OP_IO_READ_THEN_CLEAN_INVAL 5'h06
`define OP_IO_READ_THEN_DISCARD 5'h07
`define OP_FLUSH_TO_SHARED 5'h08
`define OP_FLUSH_TO_PERSIST 5'h09
`define OP_FLUSH_AND_INVALIDATE 5'h0a
`define OP_DISCARD_LINE 5'h0b
`define OP_DROP_CLEAN_LINE 5'h0c
`define OP_GAIN_WRITE_PERM 5'h0d
`define OP_GAIN_FULL_LINE_PERM 5'h0e
`define OP_WRITE_FULL 5'h0f
`define OP_WRITE_PARTIAL 5'h10
`define OP_ATOMIC_NO_RETURN 5'h11
`define OP_ATOMIC_FETCH_OP 5'h12
`define OP_ATOMIC_EXCHANGE 5'h13
`define OP_ATOMIC_CMP_EXCHANGE 5'h14
`define RSPW 1
`define RSP_DONE 1'h0
`define RSP_CPL_PAYLOAD 1'h1
`define SNPW 3
`define PROBE_DISCARD 3'h5
`define SRSPW 2
`define PROBE_ACK_NODATA 2'h0
`define PROBE_ACK_WITH_LINE 2'h1
`define PROBE_ACK_PARTIAL_LINE 2'h2
`define MISC_UNIT_BYTES 8
`define POOL_REQ 0
`define POOL_DATA 1
`define POOL_SNP 2
`define POOL_MISC 3
`define NPOOL 4
`endif

// >>> src/flow_gate_pkg.sv
package flow_gate_pkg;
`include "flow_gate_defs.svh"
  typedef logic [`OPW-1:0] op_t;
  typedef enum logic [2:0] {
    CL_COH_RD = 3'h0, CL_NC_RD = 3'h1, CL_DL = 3'h2, CL_DL_ACK = 3'h3,
    CL_WR = 3'h4, CL_AT_NORET = 3'h5, CL_AT_RET = 3'h6, CL_BAD = 3'h7
  } cls_e;
  typedef enum logic [1:0] {
    T_IDLE = 2'h0, T_WAIT_RSP = 2'h1, T_SEND_ACK = 2'h2
  } txn_state_e;
  function automatic cls_e class_of(op_t op);
    if (op <= `OP_COH_READ_SHARABLE) return CL_COH_RD;
    if (op <= `OP_IO_READ_THEN_DISCARD) return CL_NC_RD;
    if (op <= `OP_DROP_CLEAN_LINE) return CL_DL;
    if (op <= `OP_GAIN_FULL_LINE_PERM) return CL_DL_ACK;
    if (op <= `OP_WRITE_PARTIAL) return CL_WR;
    if (op == `OP_ATOMIC_NO_RETURN) return CL_AT_NORET;
    if (op <= `OP_ATOMIC_CMP_EXCHANGE) return CL_AT_RET;
    return CL_BAD;
  endfunction
  function automatic logic needs_data_credit(cls_e c);
    return c == CL_WR || c == CL_AT_NORET || c == CL_AT_RET;
  endfunction
  function automatic logic rsp_with_data(cls_e c);
    return c == CL_COH_RD || c == CL_NC_RD || c == CL_AT_RET;
  endfunction
  function automatic logic [`RSPW-1:0] expect_rsp(cls_e c);
    return rsp_with_data(c) ? `RSP_CPL_PAYLOAD : `RSP_DONE;
  endfunction
  function automatic logic ack_due(cls_e c);
    return c == CL_COH_RD || c == CL_DL_ACK;
  endfunction
endpackage

// >>> src/credit_pool.sv
`timescale 1ns/100ps
`include "flow_gate_defs.svh"
module credit_pool #(
  parameter int CRW = 6
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic grant,
  input wire logic [CRW-1:0] consume,
  output logic [CRW-1:0] count
);
  import flow_gate_pkg::*;
  typedef struct packed {
    logic [CRW-1:0] cnt;
  } pool_s;
  localparam logic [CRW-1:0] CMAX = '1;
  pool_s pool_reg;
  pool_s pool_next;
  logic grant_ok;

  if (CRW < 2) begin : g_chk
    $error("credit_pool: CRW too small");
  end

  // a grant at the ceiling is dropped unless a consume makes room
  assign grant_ok = grant && (pool_reg.cnt != CMAX || consume != '0);

  always_comb begin
    pool_next = pool_reg;
    pool_next.cnt = pool_reg.cnt + CRW'(grant_ok) - consume;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pool_reg <= '0;
    end else begin
      pool_reg <= pool_next;
    end
  end

  assign count = pool_reg.cnt;

  pool_under_a: assert property (@(posedge clk) disable iff (reset)
    consume <= pool_reg.cnt) else $error("credit consumed beyond what is held");
endmodule

// >>> src/coherent_txn_flow_credit_gate.sv
`timescale 1ns/100ps
`include "flow_gate_defs.svh"
module coherent_txn_flow_credit_gate #(
  parameter int NTXN = 8,
  parameter int NSNP = 4,
  parameter int AW = 48,
  parameter int LINE_BYTES = 64,
  parameter int DBUF = 4,
  parameter int NBUF = 4,
  parameter int CRW = 6,
  parameter int MLW = 4,
  parameter bit PARTIAL_OK = 1'b1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic req_credit_grant,
  input wire logic data_credit_grant,
  input wire logic snp_credit_grant,
  input wire logic misc_credit_grant,
  input wire logic req_valid,
  input wire flow_gate_pkg::op_t req_op,
  input wire logic req_ack_omit,
  output logic req_ready,
  output logic tx_req_valid,
  output flow_gate_pkg::op_t tx_req_op,
  output logic [$clog2(NTXN)-1:0] tx_req_id,
  output logic tx_req_ack_omit,
  input wire logic rx_rsp_valid,
  input wire logic [`RSPW-1:0] rx_rsp_op,
  input wire logic [$clog2(NTXN)-1:0] rx_rsp_id,
  output logic tx_ack_valid,
  output logic [$clog2(NTXN)-1:0] tx_ack_id,
  input wire logic hreq_valid,
  input wire flow_gate_pkg::op_t hreq_op,
  input wire logic [$clog2(NTXN)-1:0] hreq_id,
  output logic tx_cpl_valid,
  output logic [`RSPW-1:0] tx_cpl_op,
  output logic [$clog2(NTXN)-1:0] tx_cpl_id,
  input wire logic snp_valid,
  input wire logic [`SNPW-1:0] snp_op,
  input wire logic [AW-1:0] snp_addr,
  output logic snp_ready,
  output logic tx_snp_valid,
  output logic [`SNPW-1:0] tx_snp_op,
  output logic [AW-1:0] tx_snp_addr,
  output logic [$clog2(NSNP)-1:0] tx_snp_id,
  input wire logic rx_snp_rsp_valid,
  input wire logic [`SRSPW-1:0] rx_snp_rsp_op,
  input wire logic [$clog2(NSNP)-1:0] rx_snp_rsp_id,
  input wire logic misc_valid,
  input wire logic misc_credited,
  input wire logic [MLW-1:0] misc_units,
  output logic misc_ready,
  output logic tx_misc_valid,
  output logic tx_misc_credited,
  output logic [MLW-1:0] tx_misc_units,
  output logic proto_err
);
  import flow_gate_pkg::*;
  localparam int IDW = $clog2(NTXN);
  localparam int SIDW = $clog2(NSNP);
  localparam int LB = $clog2(LINE_BYTES);
  localparam logic [CRW-1:0] DBUF_C = CRW'(DBUF);
  localparam logic [CRW-1:0] NBUF_C = CRW'(NBUF);

  typedef struct packed {
    txn_state_e st;
    cls_e cls;
    logic omit;
  } ent_s;

  typedef struct packed {
    logic busy;
    logic [`SNPW-1:0] op;
    logic [AW-1:0] addr;
  } sent_s;

  typedef struct packed {
    ent_s [NTXN-1:0] ent;
    sent_s [NSNP-1:0] snp;
    logic [CRW-1:0] dbuf_used;
    logic [CRW-1:0] nbuf_used;
    logic req_v;
    op_t req_op;
    logic [IDW-1:0] req_id;
    logic req_omit;
    logic ack_v;
    logic [IDW-1:0] ack_id;
    logic cpl_v;
    logic [`RSPW-1:0] cpl_op;
    logic [IDW-1:0] cpl_id;
    logic snp_v;
    logic [`SNPW-1:0] snp_op;
    logic [AW-1:0] snp_addr;
    logic [SIDW-1:0] snp_id;
    logic misc_v;
    logic misc_cr;
    logic [MLW-1:0] misc_units;
    logic err;
  } state_s;

  state_s state_reg;
  state_s state_next;
  logic [`NPOOL-1:0] grant;
  logic [CRW-1:0] cr_cnt [`NPOOL];
  logic [CRW-1:0] cr_use [`NPOOL];
  cls_e cls;
  logic buf_ok;
  logic issue_ok;
  logic issue_fire;
  logic free_found;
  logic [IDW-1:0] free_id;
  logic ack_found;
  logic [IDW-1:0] ack_pick;
  ent_s rsp_ent;
  logic rsp_match;
  logic ack_due_now;
  logic snp_free_found;
  logic [SIDW-1:0] snp_free_id;
  logic snp_hit;
  logic snp_ok;
  logic snp_fire;
  sent_s srsp_ent;
  logic srsp_bad;
  logic misc_ok;
  logic misc_fire;
  cls_e hcls;

  if (NTXN < 2 || (1 << IDW) != NTXN || NSNP < 2 || (1 << SIDW) != NSNP
      || MLW > CRW || DBUF < 1 || NBUF < 1 || DBUF >= (1 << CRW)
      || NBUF >= (1 << CRW) || LB >= AW) begin : g_chk
    $error("flow gate: parameters out of range");
  end

  assign grant = {misc_credit_grant, snp_credit_grant, data_credit_grant,
                  req_credit_grant};

  for (genvar k = 0; k < `NPOOL; k++) begin : g_pool
    credit_pool #(
      .CRW(CRW)
    ) u_pool (
      .clk(clk),
      .reset(reset),
      .grant(grant[k]),
      .consume(cr_use[k]),
      .count(cr_cnt[k])
    );
  end

  // lowest free slot, lowest pending ack, free snoop slot, same-line lookup
  always_comb begin
    free_found = 1'b0;
    free_id = '0;
    ack_found = 1'b0;
    ack_pick = '0;
    for (int i = NTXN - 1; i >= 0; i--) begin
      if (state_reg.ent[i].st == T_IDLE) begin
        free_found = 1'b1;
        free_id = IDW'(i);
      end
      if (state_reg.ent[i].st == T_SEND_ACK) begin
        ack_found = 1'b1;
        ack_pick = IDW'(i);
      end
    end
    snp_free_found = 1'b0;
    snp_free_id = '0;
    snp_hit = 1'b0;
    for (int j = NSNP - 1; j >= 0; j--) begin
      if (!state_reg.snp[j].busy) begin
        snp_free_found = 1'b1;
        snp_free_id = SIDW'(j);
      end
      if (state_reg.snp[j].busy
          && state_reg.snp[j].addr[AW-1:LB] == snp_addr[AW-1:LB]) begin
        snp_hit = 1'b1;
      end
    end
  end

  // request gate; the link is trusted to take whatever the credits cover
  assign cls = class_of(req_op);
  assign buf_ok = rsp_with_data(cls) ? (state_reg.dbuf_used < DBUF_C)
                                     : (state_reg.nbuf_used < NBUF_C);
  assign issue_ok = cr_cnt[`POOL_REQ] != '0
      && (!needs_data_credit(cls) || cr_cnt[`POOL_DATA] != '0)
      && buf_ok && free_found && cls != CL_BAD;
  assign req_ready = issue_ok;
  assign issue_fire = req_valid && issue_ok;

  assign rsp_ent = state_reg.ent[rx_rsp_id];
  assign rsp_match = rsp_ent.st == T_WAIT_RSP
      && rx_rsp_op == expect_rsp(rsp_ent.cls);
  assign ack_due_now = ack_due(rsp_ent.cls) && !rsp_ent.omit;

  // snoop gate: credit, a reserved response slot, and no twin on the line
  assign snp_ok = cr_cnt[`POOL_SNP] != '0
      && snp_free_found
      && !snp_hit;
  assign snp_ready = snp_ok;
  assign snp_fire = snp_valid && snp_ok;

  assign srsp_ent = state_reg.snp[rx_snp_rsp_id];
  assign srsp_bad = !srsp_ent.busy
      || rx_snp_rsp_op > `PROBE_ACK_PARTIAL_LINE
      || (srsp_ent.op == `PROBE_DISCARD
          && rx_snp_rsp_op != `PROBE_ACK_NODATA)
      || (rx_snp_rsp_op == `PROBE_ACK_PARTIAL_LINE && !PARTIAL_OK);

  // zero-length credited misc is refused; uncredited always passes
  assign misc_ok = !misc_credited
      || (misc_units != '0 && CRW'(misc_units) <= cr_cnt[`POOL_MISC]);
  assign misc_ready = misc_ok;
  assign misc_fire = misc_valid && misc_ok;

  assign cr_use[`POOL_REQ] = CRW'(issue_fire);
  assign cr_use[`POOL_DATA] = CRW'(issue_fire && needs_data_credit(cls));
  assign cr_use[`POOL_SNP] = CRW'(snp_fire);
  assign cr_use[`POOL_MISC] = (misc_fire && misc_credited)
      ? CRW'(misc_units) : '0;

  assign hcls = class_of(hreq_op);

  always_comb begin
    state_next = state_reg;
    state_next.req_v = issue_fire;
    state_next.ack_v = 1'b0;
    state_next.cpl_v = hreq_valid;
    state_next.snp_v = snp_fire;
    state_next.misc_v = misc_fire;
    state_next.err = 1'b0;
    if (issue_fire) begin
      state_next.req_op = req_op;
      state_next.req_id = free_id;
      state_next.req_omit = req_ack_omit;
      state_next.ent[free_id].st = T_WAIT_RSP;
      state_next.ent[free_id].cls = cls;
      state_next.ent[free_id].omit = req_ack_omit;
    end
    if (rx_rsp_valid) begin
      if (rsp_match) begin
        state_next.ent[rx_rsp_id].st = ack_due_now ? T_SEND_ACK : T_IDLE;
      end else begin
        state_next.err = 1'b1;
      end
    end
    // acks drain one a cycle; the slot frees as the ack goes out
    if (ack_found) begin
      state_next.ack_v = 1'b1;
      state_next.ack_id = ack_pick;
      state_next.ent[ack_pick].st = T_IDLE;
    end
    state_next.dbuf_used = state_reg.dbuf_used
        + CRW'(issue_fire && rsp_with_data(cls))
        - CRW'(rx_rsp_valid && rsp_match && rsp_with_data(rsp_ent.cls));
    state_next.nbuf_used = state_reg.nbuf_used
        + CRW'(issue_fire && !rsp_with_data(cls))
        - CRW'(rx_rsp_valid && rsp_match && !rsp_with_data(rsp_ent.cls));
    if (hreq_valid) begin
      state_next.cpl_op = expect_rsp(hcls);
      state_next.cpl_id = hreq_id;
      if (hcls == CL_BAD) begin
        state_next.err = 1'b1;
      end
    end
    if (snp_fire) begin
      state_next.snp_op = snp_op;
      state_next.snp_addr = snp_addr;
      state_next.snp_id = snp_free_id;
      state_next.snp[snp_free_id].busy = 1'b1;
      state_next.snp[snp_free_id].op = snp_op;
      state_next.snp[snp_free_id].addr = snp_addr;
    end
    if (rx_snp_rsp_valid) begin
      if (srsp_bad) begin
        state_next.err = 1'b1;
      end else begin
        state_next.snp[rx_snp_rsp_id].busy = 1'b0;
      end
    end
    if (misc_fire) begin
      state_next.misc_cr = misc_credited;
      state_next.misc_units = misc_units;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign tx_req_valid = state_reg.req_v;
  assign tx_req_op = state_reg.req_op;
  assign tx_req_id = state_reg.req_id;
  assign tx_req_ack_omit = state_reg.req_omit;
  assign tx_ack_valid = state_reg.ack_v;
  assign tx_ack_id = state_reg.ack_id;
  assign tx_cpl_valid = state_reg.cpl_v;
  assign tx_cpl_op = state_reg.cpl_op;
  assign tx_cpl_id = state_reg.cpl_id;
  assign tx_snp_valid = state_reg.snp_v;
  assign tx_snp_op = state_reg.snp_op;
  assign tx_snp_addr = state_reg.snp_addr;
  assign tx_snp_id = state_reg.snp_id;
  assign tx_misc_valid = state_reg.misc_v;
  assign tx_misc_credited = state_reg.misc_cr;
  assign tx_misc_units = state_reg.misc_units;
  assign proto_err = state_reg.err;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence s_issue;
    req_valid && req_ready;
  endsequence
  sequence s_sent;
    tx_req_valid && tx_req_id == $past(free_id);
  endsequence
  sequence s_ack_due;
    rx_rsp_valid && rsp_match && ack_due_now;
  endsequence
  sequence s_no_ack;
    rx_rsp_valid && rsp_match && !ack_due_now;
  endsequence

  req_credit_a: assert property (
    s_issue |-> cr_cnt[`POOL_REQ] != '0 ##1 s_sent)
    else $error("request issued without request credit");
  data_credit_a: assert property (
    s_issue ##0 needs_data_credit(cls) |-> cr_cnt[`POOL_DATA] != '0)
    else $error("payload request issued without data credit");
  rsp_buffer_a: assert property (
    state_reg.dbuf_used <= DBUF_C && state_reg.nbuf_used <= NBUF_C)
    else $error("response buffering overcommitted");
  final_ack_a: assert property (
    s_ack_due |=> ##[1:9] tx_ack_valid)
    else $error("final ack not sent after response");
  no_ack_a: assert property (
    s_no_ack |=> state_reg.ent[$past(rx_rsp_id)].st == T_IDLE)
    else $error("transaction not retired on its last response");
  home_payload_a: assert property (
    hreq_valid && rsp_with_data(hcls)
    |=> tx_cpl_valid && tx_cpl_op == `RSP_CPL_PAYLOAD)
    else $error("payload class not answered with completion payload");
  home_done_a: assert property (
    hreq_valid && !rsp_with_data(hcls) |=> tx_cpl_valid && tx_cpl_op == `RSP_DONE)
    else $error("dataless or write class not answered with done");
  snoop_gate_a: assert property (
    snp_valid && snp_ready |-> cr_cnt[`POOL_SNP] != '0 ##1 tx_snp_valid
    ##0 state_reg.snp[tx_snp_id].busy)
    else $error("snoop issued without credit or slot");
  snoop_line_a: assert property (
    snp_valid && snp_hit |-> !snp_ready)
    else $error("second snoop to a busy line");
  probe_discard_a: assert property (
    rx_snp_rsp_valid && srsp_ent.busy && srsp_ent.op == `PROBE_DISCARD
    && rx_snp_rsp_op != `PROBE_ACK_NODATA |=> proto_err)
    else $error("data answer to probe_discard not flagged");
  misc_length_a: assert property (
    misc_valid && misc_ready && misc_credited
    |-> CRW'(misc_units) <= cr_cnt[`POOL_MISC]
    ##1 tx_misc_valid && tx_misc_units == $past(misc_units))
    else $error("credited misc longer than credits allow");
  misc_free_a: assert property (
    misc_valid && !misc_credited |-> misc_ready ##1 tx_misc_valid)
    else $error("uncredited misc held back");
endmodule

// >>> bench/remote_home_model.sv
`timescale 1ns/100ps
`include "flow_gate_defs.svh"
module remote_home_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic hold,
  input wire logic slow,
  input wire logic snp_data,
  input wire logic tx_req_valid,
  input wire flow_gate_pkg::op_t tx_req_op,
  input wire logic [2:0] tx_req_id,
  input wire logic tx_snp_valid,
  input wire logic [1:0] tx_snp_id,
  output logic rx_rsp_valid,
  output logic [`RSPW-1:0] rx_rsp_op,
  output logic [2:0] rx_rsp_id,
  output logic rx_snp_rsp_valid,
  output logic [`SRSPW-1:0] rx_snp_rsp_op,
  output logic [1:0] rx_snp_rsp_id
);
  import flow_gate_pkg::*;
  logic [3:0] rq[$];
  logic [2:0] sq[$];
  logic [2:0] s;
  logic [1:0] gap;
  initial begin
    {rx_rsp_valid, rx_rsp_op, rx_rsp_id} = '0;
    {rx_snp_rsp_valid, rx_snp_rsp_op, rx_snp_rsp_id} = '0;
  end
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      rq.delete();
      sq.delete();
      gap <= 2'h0;
      rx_rsp_valid <= 1'b0;
      rx_snp_rsp_valid <= 1'b0;
    end else begin
      if (tx_req_valid)
        rq.push_back({tx_req_op <= 5'h07 || tx_req_op >= 5'h12, tx_req_id});
      if (tx_snp_valid)
        sq.push_back({snp_data, tx_snp_id});
      // slow mode answers only every fourth cycle
      gap <= slow ? gap + 2'h1 : 2'h3;
      if (!hold && gap == 2'h3 && rq.size() > 0) begin
        {rx_rsp_op, rx_rsp_id} <= rq.pop_front();
        rx_rsp_valid <= 1'b1;
      end else begin
        // idle lines keep moving so a stale value never looks valid
        {rx_rsp_op, rx_rsp_id} <= ~{rx_rsp_op, rx_rsp_id};
        rx_rsp_valid <= 1'b0;
      end
      if (!hold && sq.size() > 0) begin
        s = sq.pop_front();
        rx_snp_rsp_op <= s[2] ? `PROBE_ACK_WITH_LINE : `PROBE_ACK_NODATA;
        rx_snp_rsp_id <= s[1:0];
        rx_snp_rsp_valid <= 1'b1;
      end else begin
        {rx_snp_rsp_op, rx_snp_rsp_id} <= ~{rx_snp_rsp_op, rx_snp_rsp_id};
        rx_snp_rsp_valid <= 1'b0;
      end
    end
  end
endmodule

// >>> bench/coherent_txn_flow_credit_gate_test.sv
`timescale 1ns/100ps
`include "flow_gate_defs.svh"
module coherent_txn_flow_credit_gate_test;
  import flow_gate_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] grants = 4'h0;
  logic req_valid = 1'b0, req_ack_omit = 1'b0, hreq_valid = 1'b0, snp_valid = 1'b0;
  logic misc_valid = 1'b0, misc_credited = 1'b0, hold = 1'b0, slow = 1'b0, snp_data = 1'b0;
  op_t req_op = 5'h00, hreq_op = 5'h00, tx_req_op;
  logic [2:0] hreq_id = 3'h0, snp_op = 3'h0, tx_snp_op, tx_req_id, tx_ack_id, tx_cpl_id, rx_rsp_id;
  logic [47:0] snp_addr = 48'h0, tx_snp_addr;
  logic [3:0] misc_units = 4'h0, tx_misc_units;
  logic req_ready, tx_req_valid, tx_req_ack_omit, rx_rsp_valid, tx_ack_valid, tx_cpl_valid;
  logic snp_ready, tx_snp_valid, rx_snp_rsp_valid, misc_ready, tx_misc_valid, tx_misc_credited;
  logic proto_err;
  logic [`RSPW-1:0] rx_rsp_op, tx_cpl_op;
  logic [1:0] tx_snp_id, rx_snp_rsp_id, rx_snp_rsp_op;
  logic [47:0] exp_req[$], exp_cpl[$], exp_snp[$], exp_misc[$];
  int fails = 0, num_checks = 0, exp_acks = 0, n_ack = 0, n_err = 0;
  logic [7:0] ack_pend = 8'h0, live = 8'h0;

  always #20 clk = ~clk;

  // shallow response buffering so a full buffer is reachable in a few requests
  coherent_txn_flow_credit_gate #(.DBUF(2), .NBUF(2)) uut (
    .clk(clk), .reset(reset), .req_credit_grant(grants[3]), .data_credit_grant(grants[2]),
    .snp_credit_grant(grants[1]), .misc_credit_grant(grants[0]), .req_valid(req_valid),
    .req_op(req_op), .req_ack_omit(req_ack_omit), .req_ready(req_ready),
    .tx_req_valid(tx_req_valid), .tx_req_op(tx_req_op), .tx_req_id(tx_req_id),
    .tx_req_ack_omit(tx_req_ack_omit), .rx_rsp_valid(rx_rsp_valid), .rx_rsp_op(rx_rsp_op),
    .rx_rsp_id(rx_rsp_id), .tx_ack_valid(tx_ack_valid), .tx_ack_id(tx_ack_id),
    .hreq_valid(hreq_valid), .hreq_op(hreq_op), .hreq_id(hreq_id), .tx_cpl_valid(tx_cpl_valid),
    .tx_cpl_op(tx_cpl_op), .tx_cpl_id(tx_cpl_id), .snp_valid(snp_valid), .snp_op(snp_op),
    .snp_addr(snp_addr), .snp_ready(snp_ready), .tx_snp_valid(tx_snp_valid),
    .tx_snp_op(tx_snp_op), .tx_snp_addr(tx_snp_addr), .tx_snp_id(tx_snp_id),
    .rx_snp_rsp_valid(rx_snp_rsp_valid), .rx_snp_rsp_op(rx_snp_rsp_op),
    .rx_snp_rsp_id(rx_snp_rsp_id), .misc_valid(misc_valid), .misc_credited(misc_credited),
    .misc_units(misc_units), .misc_ready(misc_ready), .tx_misc_valid(tx_misc_valid),
    .tx_misc_credited(tx_misc_credited), .tx_misc_units(tx_misc_units), .proto_err(proto_err));

  remote_home_model home (.clk(clk), .reset(reset), .hold(hold), .slow(slow),
    .snp_data(snp_data), .tx_req_valid(tx_req_valid), .tx_req_op(tx_req_op),
    .tx_req_id(tx_req_id), .tx_snp_valid(tx_snp_valid), .tx_snp_id(tx_snp_id),
    .rx_rsp_valid(rx_rsp_valid), .rx_rsp_op(rx_rsp_op), .rx_rsp_id(rx_rsp_id),
    .rx_snp_rsp_valid(rx_snp_rsp_valid), .rx_snp_rsp_op(rx_snp_rsp_op),
    .rx_snp_rsp_id(rx_snp_rsp_id));

  task automatic chk_val(logic [47:0] got, logic [47:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(logic got, logic exp);
    chk_val({47'h0, got}, {47'h0, exp});
  endtask

  task automatic pop(ref logic [47:0] q[$], input logic [47:0] got);
    if (q.size() == 0)
      chk_val(got, ~got);
    else
      chk_val(got, q.pop_front());
  endtask

  task automatic grant(logic [3:0] which, int n);
    repeat (n) begin
      @(posedge clk);
      grants <= which;
    end
    @(posedge clk);
    grants <= 4'h0;
  endtask

  // issue and snoop wait a bounded time for ready only when acceptance is expected; misc samples ready once
  task automatic issue(op_t op, logic omit, logic rdy);
    int n;
    n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req_op <= op;
    req_ack_omit <= omit;
    do begin
      @(negedge clk);
      n++;
    end while (rdy && req_ready !== 1'b1 && n < 50);
    chk_flag(req_ready, rdy);
    if (rdy)
      exp_req.push_back({42'h0, omit, op});
    if (rdy && !omit && (op <= 5'h03 || op == 5'h0d || op == 5'h0e))
      exp_acks++;
    @(posedge clk);
    req_valid <= 1'b0;
    req_op <= ~op;
  endtask

  task automatic snoop(logic [2:0] op, logic [47:0] a, logic dat, logic rdy);
    int n;
    n = 0;
    @(posedge clk);
    snp_valid <= 1'b1;
    snp_op <= op;
    snp_addr <= a;
    snp_data <= dat;
    do begin
      @(negedge clk);
      n++;
    end while (rdy && snp_ready !== 1'b1 && n < 50);
    chk_flag(snp_ready, rdy);
    if (rdy)
      exp_snp.push_back({op, a[44:0]});
    @(posedge clk);
    snp_valid <= 1'b0;
    snp_addr <= ~a;
  endtask

  task automatic misc(logic cred, logic [3:0] units, logic rdy);
    @(posedge clk);
    misc_valid <= 1'b1;
    misc_credited <= cred;
    misc_units <= units;
    @(negedge clk);
    chk_flag(misc_ready, rdy);
    if (rdy)
      exp_misc.push_back({43'h0, cred, units});
    @(posedge clk);
    misc_valid <= 1'b0;
  endtask

  task automatic tally_and_finish;
    if (fails == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk) begin
    if (!reset) begin
      if (tx_req_valid)
        pop(exp_req, {42'h0, tx_req_ack_omit, tx_req_op});
      if (tx_cpl_valid)
        pop(exp_cpl, {44'h0, tx_cpl_id, tx_cpl_op});
      if (tx_snp_valid)
        pop(exp_snp, {tx_snp_op, tx_snp_addr[44:0]});
      if (tx_misc_valid)
        pop(exp_misc, {43'h0, tx_misc_credited, tx_misc_units});
      if (tx_req_valid) begin
        chk_flag(live[tx_req_id], 1'b0);
        live[tx_req_id] = 1'b1;
        ack_pend[tx_req_id] = !tx_req_ack_omit
            && (tx_req_op <= 5'h03 || tx_req_op == 5'h0d || tx_req_op == 5'h0e);
      end
      if (rx_rsp_valid && !ack_pend[rx_rsp_id])
        live[rx_rsp_id] = 1'b0;
      if (tx_ack_valid) begin
        n_ack++;
        chk_flag(ack_pend[tx_ack_id], 1'b1);
        ack_pend[tx_ack_id] = 1'b0;
        live[tx_ack_id] = 1'b0;
      end
      if (proto_err)
        n_err++;
    end
  end

  initial begin
    #400000;
    fails++;
    tally_and_finish;
  end

  initial begin
    int i;
    void'($urandom(84));
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    issue(5'h00, 1'b0, 1'b0);
    snoop(3'h0, 48'h1000, 1'b0, 1'b0);
    misc(1'b1, 4'h1, 1'b0);
    misc(1'b0, 4'h5, 1'b1);
    grant(4'h8, 2);
    issue(5'h0f, 1'b0, 1'b0);
    issue(5'h11, 1'b0, 1'b0);
    issue(5'h15, 1'b0, 1'b0);
    grant(4'h4, 30);
    grant(4'h8, 60);
    hold <= 1'b1;
    issue(5'h04, 1'b0, 1'b1);
    issue(5'h05, 1'b0, 1'b1);
    issue(5'h06, 1'b0, 1'b0);
    issue(5'h08, 1'b0, 1'b1);
    issue(5'h09, 1'b0, 1'b1);
    issue(5'h0a, 1'b0, 1'b0);
    hold <= 1'b0;
    for (i = 0; i < 42; i++) begin
      slow <= 1'($urandom);
      issue(5'(i % 21), 1'(i / 21), 1'b1);
    end
    for (i = 0; i < 8; i++)
      issue(5'($urandom % 21), 1'($urandom), 1'b1);
    // the last home request carries an unknown opcode: done answer plus an error
    for (i = 0; i < 22; i++) begin
      @(posedge clk);
      hreq_valid <= 1'b1;
      hreq_op <= 5'(i);
      hreq_id <= 3'(i);
      exp_cpl.push_back({44'h0, 3'(i), (i < 8 || i > 17) && i < 21});
    end
    @(posedge clk);
    hreq_valid <= 1'b0;
    hreq_op <= 5'h1f;
    grant(4'h2, 10);
    hold <= 1'b1;
    snoop(3'h1, 48'h2040, 1'b0, 1'b1);
    snoop(3'h2, 48'h2078, 1'b0, 1'b0);
    snoop(3'h3, 48'h2080, 1'b0, 1'b1);
    snoop(3'h0, 48'h5000, 1'b0, 1'b1);
    snoop(3'h0, 48'h5040, 1'b0, 1'b1);
    snoop(3'h0, 48'h5080, 1'b0, 1'b0);
    hold <= 1'b0;
    for (i = 0; i < 5; i++)
      snoop(3'(i), 48'h3000 + 48'(i * 64), 1'($urandom), 1'b1);
    snoop(3'h5, 48'h4000, 1'b1, 1'b1);
    grant(4'h1, 3);
    misc(1'b1, 4'h4, 1'b0);
    misc(1'b1, 4'h3, 1'b1);
    misc(1'b1, 4'h1, 1'b0);
    misc(1'b0, 4'h2, 1'b1);
    repeat (40) @(posedge clk);
    chk_val(48'(n_ack), 48'(exp_acks));
    chk_val(48'(n_err), 48'h2);
    chk_val(48'(live), 48'h0);
    chk_val(48'(exp_req.size() + exp_cpl.size() + exp_snp.size() + exp_misc.size()), 48'h0);
    tally_and_finish;
  end
endmodule
